// [rtl/pst_accum.sv]
// Purpose: OR-ing (sticky) error accumulator for one test run.
// Assumes: clear_i comes with the start of a run.
// Notes: Bits outside mask_i are dropped on entry.
`default_nettype none
module pst_accum (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic valid_i,
  input wire logic [31:0] vec_i,
  input wire logic [31:0] mask_i,
  output logic [31:0] code_o
);
  import pst_pkg::*;
  typedef struct packed {
    logic [31:0] code;
  } pst_acc_t;
  pst_acc_t r_ff, nxt_r;

  always_comb begin
    nxt_r = r_ff;
    if (clear_i) begin
      nxt_r.code = 32'h00000000;
    end else if (valid_i) begin
      nxt_r.code = r_ff.code | (vec_i & mask_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign code_o = r_ff.code;
endmodule
`default_nettype wire

// [rtl/pst_pkg.sv]
// Purpose: Constants, types and helpers of the power-on self-test reporter.
// Assumes: 20 MHz clk_i; test engine and bus share that clock.
// Notes: Error numbers are held as two BCD digits, as they are shown.
`default_nettype none
package pst_pkg;
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int BEEP_MS = 100;
  localparam logic [7:0] BEEP_TICKS = 8'(BEEP_MS);

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FATAL = 8'h08;
  localparam logic [7:0] OFF_REMOTE = 8'h0c;
  localparam logic [7:0] OFF_NONFATAL = 8'h10;
  localparam logic [7:0] OFF_DEMAND = 8'h14;
  localparam logic [7:0] OFF_ERROR_STRING_QUERY = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  localparam int CTRL_START_BIT = 0;
  localparam int IRQ_FATAL_FAIL = 0;
  localparam int IRQ_NONFATAL_DONE = 1;
  localparam int IRQ_NONFATAL_FAIL = 2;
  localparam int IRQ_DEMAND_DONE = 3;
  localparam int IRQ_DEMAND_FAIL = 4;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

  localparam logic [7:0] ERR_NUM_NONE = 8'h00;
  localparam logic [7:0] ERR_NUM_FATAL = 8'h80;
  localparam logic [7:0] ERR_NUM_NONFATAL = 8'h26;
  localparam logic [7:0] ERR_NUM_DEMAND = 8'h27;
  localparam logic [3:0] DIGITS_FATAL = 4'h4;
  localparam logic [3:0] DIGITS_NONFATAL = 4'h6;
  localparam logic [3:0] DIGITS_DEMAND = 4'h8;

  localparam logic [31:0] MASK_FATAL = 32'h0000ffff;
  localparam logic [31:0] MASK_NONFATAL = 32'h007fffff;
  localparam logic [31:0] MASK_DEMAND = 32'h01fffbff;

  typedef enum logic [1:0] {
    KIND_FATAL = 2'h0,
    KIND_NONFATAL = 2'h1,
    KIND_DEMAND = 2'h2
  } pst_kind_t;

  typedef enum logic [2:0] {
    MSG_NONE = 3'h0,
    MSG_POWER_ON_FAILED = 3'h1,
    MSG_SELF_TEST_OK = 3'h2,
    MSG_SELF_TEST_FAILED = 3'h3
  } pst_msg_t;

  typedef enum logic [5:0] {
    ST_BOOT = 6'h01,
    ST_FATAL = 6'h02,
    ST_LOCK = 6'h04,
    ST_NONFATAL = 6'h08,
    ST_READY = 6'h10,
    ST_DEMAND = 6'h20
  } pst_state_t;

  // Unused code bits are masked so they can never read as failures
  function automatic logic [31:0] kind_mask(input pst_kind_t k);
    unique case (k)
      KIND_FATAL: kind_mask = MASK_FATAL;
      KIND_NONFATAL: kind_mask = MASK_NONFATAL;
      default: kind_mask = MASK_DEMAND;
    endcase
  endfunction

  // Memory failures at 14 and 15 fold into the RAM flag
  function automatic logic [7:0] reduce_fatal(input logic [15:0] f);
    reduce_fatal = {1'b0, 1'b0, f[13], f[12], 1'b0, |f[11:10],
                    |{f[15:14], f[9:6]}, |f[5:0]};
  endfunction
endpackage
`default_nettype wire

// [rtl/pst_reporter.sv]
// Purpose: Sequences the fatal, non-fatal and on-demand self-tests and reports codes.
// Assumes: Test engine on clk_i; it raises done only after start, fail bits in code layout.
// Notes: After a fatal failure only rst_i brings the block back.
`default_nettype none
module pst_reporter #(
  parameter int TICK_CYCLES = pst_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic test_start_o,
  output pst_pkg::pst_kind_t test_kind_o,
  output logic plugin_inhibit_o,
  output logic preserve_state_o,
  input wire logic test_fail_valid_i,
  input wire logic [31:0] test_fail_i,
  input wire logic test_done_i,
  output logic [7:0] disp_err_num_o,
  output logic [31:0] disp_code_o,
  output logic [3:0] disp_digits_o,
  output pst_pkg::pst_msg_t disp_msg_o,
  output logic disp_all_seg_o,
  output logic annunciator_o,
  output logic ready_o,
  output logic locked_o,
  output logic beeper_o,
  output logic [7:0] remote_code_o,
  output logic remote_valid_o
);
  import pst_pkg::*;

  typedef struct packed {
    pst_state_t st;
    logic start;
    pst_kind_t kind;
    logic [15:0] fatal;
    logic [7:0] remote;
    logic remote_vld;
    logic [23:0] nonfat;
    logic [31:0] demand;
    logic [7:0] err_num;
    logic [31:0] disp_code;
    logic [3:0] digits;
    pst_msg_t msg;
    logic all_seg;
    logic tone;
    logic beep;
    logic annunc;
    logic ready;
    logic locked;
    logic inhibit;
    logic preserve;
    logic req;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic irq;
    logic ack;
    logic [31:0] rdat;
  } pst_top_t;

  pst_top_t r_ff, nxt_r;
  logic [31:0] acc_code;
  logic [31:0] final_code;
  logic [4:0] ev;
  logic wr;
  logic rd_req;

  pst_accum u_accum (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(nxt_r.start),
    .valid_i(test_fail_valid_i),
    .vec_i(test_fail_i),
    .mask_i(kind_mask(r_ff.kind)),
    .code_o(acc_code)
  );

  pst_tone #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tone (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .beep_i(r_ff.beep),
    .cont_i(r_ff.tone),
    .beeper_o(beeper_o)
  );

  always_comb begin
    nxt_r = r_ff;
    ev = 5'h00;
    nxt_r.start = 1'b0;
    nxt_r.beep = 1'b0;
    // Fail bits arriving with done still count
    final_code = acc_code | (test_fail_valid_i ? (test_fail_i & kind_mask(r_ff.kind)) : 32'h0);
    wr = wb_cyc_i && wb_stb_i && r_ff.ack && wb_we_i;
    rd_req = wb_cyc_i && wb_stb_i && !r_ff.ack;

    unique case (r_ff.st)
      ST_BOOT: begin
        nxt_r.start = 1'b1;
        nxt_r.kind = KIND_FATAL;
        nxt_r.inhibit = 1'b1;
        nxt_r.st = ST_FATAL;
      end
      ST_FATAL: begin
        if (test_done_i) begin
          nxt_r.fatal = final_code[15:0];
          nxt_r.remote = reduce_fatal(final_code[15:0]);
          nxt_r.remote_vld = 1'b1;
          if (final_code[15:0] != 16'h0000) begin
            nxt_r.st = ST_LOCK;
            nxt_r.locked = 1'b1;
            nxt_r.beep = 1'b1;
            nxt_r.err_num = ERR_NUM_FATAL;
            nxt_r.disp_code = {16'h0000, final_code[15:0]};
            nxt_r.digits = DIGITS_FATAL;
            nxt_r.inhibit = 1'b0;
            ev[IRQ_FATAL_FAIL] = 1'b1;
          end else begin
            nxt_r.start = 1'b1;
            nxt_r.kind = KIND_NONFATAL;
            nxt_r.st = ST_NONFATAL;
          end
        end
      end
      ST_LOCK: begin
        nxt_r.st = ST_LOCK;
      end
      ST_NONFATAL: begin
        if (test_done_i) begin
          nxt_r.nonfat = final_code[23:0];
          nxt_r.st = ST_READY;
          nxt_r.ready = 1'b1;
          nxt_r.inhibit = 1'b0;
          ev[IRQ_NONFATAL_DONE] = 1'b1;
          if (final_code[23:0] != 24'h000000) begin
            nxt_r.err_num = ERR_NUM_NONFATAL;
            nxt_r.msg = MSG_POWER_ON_FAILED;
            nxt_r.annunc = 1'b1;
            nxt_r.disp_code = {8'h00, final_code[23:0]};
            nxt_r.digits = DIGITS_NONFATAL;
            ev[IRQ_NONFATAL_FAIL] = 1'b1;
          end
        end
      end
      ST_READY: begin
        if (r_ff.req) begin
          nxt_r.req = 1'b0;
          nxt_r.start = 1'b1;
          nxt_r.kind = KIND_DEMAND;
          nxt_r.st = ST_DEMAND;
          nxt_r.all_seg = 1'b1;
          nxt_r.tone = 1'b1;
          nxt_r.inhibit = 1'b1;
          nxt_r.preserve = 1'b1;
          nxt_r.msg = MSG_NONE;
          nxt_r.err_num = ERR_NUM_NONE;
          // A stale code from an earlier run must not sit beside a pass message
          nxt_r.disp_code = 32'h00000000;
        end
      end
      ST_DEMAND: begin
        if (test_done_i) begin
          nxt_r.demand = final_code;
          nxt_r.st = ST_READY;
          nxt_r.all_seg = 1'b0;
          nxt_r.tone = 1'b0;
          nxt_r.inhibit = 1'b0;
          nxt_r.preserve = 1'b0;
          ev[IRQ_DEMAND_DONE] = 1'b1;
          if (final_code != 32'h00000000) begin
            nxt_r.beep = 1'b1;
            nxt_r.err_num = ERR_NUM_DEMAND;
            nxt_r.msg = MSG_SELF_TEST_FAILED;
            nxt_r.disp_code = final_code;
            nxt_r.digits = DIGITS_DEMAND;
            ev[IRQ_DEMAND_FAIL] = 1'b1;
          end else begin
            nxt_r.msg = MSG_SELF_TEST_OK;
          end
        end
      end
    endcase

    // Bus side: ack one cycle after the request, writes land on the acked edge
    nxt_r.ack = rd_req;
    if (rd_req) begin
      unique case (wb_adr_i)
        OFF_CTRL: nxt_r.rdat = {31'h0, r_ff.req};
        OFF_STATUS: nxt_r.rdat = {22'h0, r_ff.locked, r_ff.ready, r_ff.annunc,
                                  r_ff.req, r_ff.st};
        OFF_FATAL: nxt_r.rdat = {16'h0, r_ff.fatal};
        OFF_REMOTE: nxt_r.rdat = {23'h0, r_ff.remote_vld, r_ff.remote};
        OFF_NONFATAL: nxt_r.rdat = {8'h0, r_ff.nonfat};
        OFF_DEMAND: nxt_r.rdat = r_ff.demand;
        OFF_ERROR_STRING_QUERY: nxt_r.rdat = {(r_ff.nonfat != 24'h0) ? ERR_NUM_NONFATAL :
                                              ERR_NUM_NONE, r_ff.nonfat};
        OFF_IRQ_STATUS: nxt_r.rdat = {27'h0, r_ff.irq_stat};
        OFF_IRQ_MASK: nxt_r.rdat = {27'h0, r_ff.irq_mask};
        default: nxt_r.rdat = 32'h00000000;
      endcase
    end
    if (wr && wb_sel_i[0]) begin
      // A request while locked is dropped; one made during power-up waits
      if (wb_adr_i == OFF_CTRL && wb_dat_i[CTRL_START_BIT] && !r_ff.locked) begin
        nxt_r.req = 1'b1;
      end
      if (wb_adr_i == OFF_IRQ_MASK) begin
        nxt_r.irq_mask = wb_dat_i[4:0];
      end
      if (wb_adr_i == OFF_IRQ_STATUS) begin
        nxt_r.irq_stat = r_ff.irq_stat & ~wb_dat_i[4:0];
      end
    end
    // Set wins over a clear in the same cycle
    nxt_r.irq_stat = nxt_r.irq_stat | ev;
    nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '{st: ST_BOOT, kind: KIND_FATAL, msg: MSG_NONE, irq_mask: IRQ_MASK_RST,
                default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign wb_dat_o = r_ff.rdat;
  assign wb_ack_o = r_ff.ack;
  assign irq_o = r_ff.irq;
  assign test_start_o = r_ff.start;
  assign test_kind_o = r_ff.kind;
  assign plugin_inhibit_o = r_ff.inhibit;
  assign preserve_state_o = r_ff.preserve;
  assign disp_err_num_o = r_ff.err_num;
  assign disp_code_o = r_ff.disp_code;
  assign disp_digits_o = r_ff.digits;
  assign disp_msg_o = r_ff.msg;
  assign disp_all_seg_o = r_ff.all_seg;
  assign annunciator_o = r_ff.annunc;
  assign ready_o = r_ff.ready;
  assign locked_o = r_ff.locked;
  assign remote_code_o = r_ff.remote;
  assign remote_valid_o = r_ff.remote_vld;

  property p_fatal_lock;
    @(posedge clk_i) disable iff (rst_i)
      (r_ff.st == ST_FATAL && test_done_i && final_code[15:0] != 16'h0000) |=>
      locked_o && disp_err_num_o == ERR_NUM_FATAL && disp_digits_o == DIGITS_FATAL;
  endproperty
  a_fatal_lock: assert property (p_fatal_lock) else $error("fatal failure not shown");

  property p_lock_holds;
    @(posedge clk_i) disable iff (rst_i)
      locked_o |=> locked_o && !test_start_o && !ready_o;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock released");

  property p_remote_map;
    @(posedge clk_i) disable iff (rst_i)
      remote_valid_o |-> remote_code_o[6] == 1'b0 &&
      remote_code_o[0] == |r_ff.fatal[5:0] && remote_code_o[4] == r_ff.fatal[12];
  endproperty
  a_remote_map: assert property (p_remote_map) else $error("remote code wrong");

  property p_nonfat_fail;
    @(posedge clk_i) disable iff (rst_i)
      (r_ff.st == ST_NONFATAL && test_done_i && final_code[23:0] != 24'h0) |=>
      ready_o && annunciator_o && disp_err_num_o == ERR_NUM_NONFATAL ##1 annunciator_o;
  endproperty
  a_nonfat_fail: assert property (p_nonfat_fail) else $error("non-fatal fail wrong");

  property p_unused_bits;
    @(posedge clk_i) disable iff (rst_i)
      r_ff.nonfat[23] == 1'b0 && r_ff.demand[10] == 1'b0 && r_ff.demand[31:25] == 7'h00;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused code bit set");

  property p_lamp_tone;
    @(posedge clk_i) disable iff (rst_i)
      (disp_all_seg_o && $past(disp_all_seg_o)) |-> beeper_o;
  endproperty
  a_lamp_tone: assert property (p_lamp_tone) else $error("no tone with segments");

  sequence s_demand_fail;
    r_ff.st == ST_DEMAND && test_done_i && final_code != 32'h0;
  endsequence
  sequence s_fail_shown;
    disp_err_num_o == ERR_NUM_DEMAND && disp_digits_o == DIGITS_DEMAND &&
    disp_msg_o == MSG_SELF_TEST_FAILED ##1 beeper_o [*2];
  endsequence
  property p_demand_fail;
    @(posedge clk_i) disable iff (rst_i)
      s_demand_fail |=> s_fail_shown;
  endproperty
  a_demand_fail: assert property (p_demand_fail) else $error("demand fail wrong");

  property p_inhibit;
    @(posedge clk_i) disable iff (rst_i)
      test_start_o |-> plugin_inhibit_o && acc_code == 32'h0;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("start without inhibit or clear");

  property p_preserve;
    @(posedge clk_i) disable iff (rst_i)
      (test_start_o && test_kind_o == KIND_DEMAND) |-> preserve_state_o && disp_all_seg_o;
  endproperty
  a_preserve: assert property (p_preserve) else $error("demand test not protected");

  // Sampled reset keeps the attempt at the release edge quiet
  property p_boot_fatal;
    @(posedge clk_i) disable iff (rst_i)
      (r_ff.st == ST_BOOT && !rst_i) |=> test_start_o && test_kind_o == KIND_FATAL;
  endproperty
  a_boot_fatal: assert property (p_boot_fatal) else $error("fatal test not first");

  property p_nonfat_start;
    @(posedge clk_i) disable iff (rst_i)
      (r_ff.st == ST_FATAL && test_done_i && final_code[15:0] == 16'h0000) |=>
      test_start_o && test_kind_o == KIND_NONFATAL && !locked_o;
  endproperty
  a_nonfat_start: assert property (p_nonfat_start) else $error("non-fatal not started");

  property p_nonfat_ready;
    @(posedge clk_i) disable iff (rst_i)
      (r_ff.st == ST_NONFATAL && test_done_i) |=> ready_o && !plugin_inhibit_o && !locked_o;
  endproperty
  a_nonfat_ready: assert property (p_nonfat_ready) else $error("ready not reached");

  property p_fatal_remote;
    @(posedge clk_i) disable iff (rst_i)
      (r_ff.st == ST_FATAL && test_done_i) |=> remote_valid_o && remote_code_o[6] == 1'b0;
  endproperty
  a_fatal_remote: assert property (p_fatal_remote) else $error("remote code not sent");

  property p_demand_pass;
    @(posedge clk_i) disable iff (rst_i)
      (r_ff.st == ST_DEMAND && test_done_i && final_code == 32'h00000000) |=>
      disp_msg_o == MSG_SELF_TEST_OK && disp_err_num_o == ERR_NUM_NONE && !disp_all_seg_o;
  endproperty
  a_demand_pass: assert property (p_demand_pass) else $error("demand pass not shown");
endmodule
`default_nettype wire

// [rtl/pst_tone.sv]
// Purpose: Beeper driver: timed beep plus steady tone.
// Assumes: beep_i is a one-cycle pulse.
// Notes: Beep length is counted in millisecond ticks from a divider.
`default_nettype none
module pst_tone #(
  parameter int TICK_CYCLES = pst_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic beep_i,
  input wire logic cont_i,
  output logic beeper_o
);
  import pst_pkg::*;
  typedef struct packed {
    logic [14:0] div;
    logic [7:0] left;
    logic on;
  } pst_tone_t;
  pst_tone_t r_ff, nxt_r;
  logic tick;

  always_comb begin
    nxt_r = r_ff;
    tick = (r_ff.div == 15'(TICK_CYCLES - 1));
    nxt_r.div = tick ? 15'h0000 : r_ff.div + 15'h0001;
    if (beep_i) begin
      nxt_r.left = BEEP_TICKS;
      nxt_r.div = 15'h0000;
    end else if (tick && r_ff.left != 8'h00) begin
      nxt_r.left = r_ff.left - 8'h01;
    end
    nxt_r.on = cont_i || beep_i || (nxt_r.left != 8'h00);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign beeper_o = r_ff.on;
endmodule
`default_nettype wire

// [verification/pst_engine_model.sv]
// Purpose: Test engine model: answers each start with two split fail pulses, done with the second.
// Assumes: Fail vectors and delay are set by the bench before a start.
// Notes: Idle fail bus toggles so stale bits are never mistaken for data.
`default_nettype none
module pst_engine_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire pst_pkg::pst_kind_t kind_i,
  input wire logic [31:0] fatal_vec_i,
  input wire logic [31:0] nonfatal_vec_i,
  input wire logic [31:0] demand_vec_i,
  input wire logic [7:0] delay_i,
  output logic fail_valid_o,
  output logic [31:0] fail_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pst_pkg::*;
  logic [31:0] vec;
  logic [7:0] cnt;
  logic busy;
  logic phase;
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      fail_valid_o <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 32'h0;
    end else begin
      fail_valid_o <= 1'b0;
      done_o <= 1'b0;
      fail_o <= ~fail_o;
      if (start_i) begin
        busy <= 1'b1;
        cnt <= delay_i;
        phase <= 1'b0;
        vec <= (kind_i == KIND_FATAL) ? fatal_vec_i :
               (kind_i == KIND_NONFATAL) ? nonfatal_vec_i : demand_vec_i;
      end else if (busy) begin
        if (cnt != 8'h0) begin
          cnt <= cnt - 8'h1;
        end else if (!phase) begin
          // Half the bits first, so the reporter has to OR two pulses together
          fail_valid_o <= 1'b1;
          fail_o <= vec & 32'h55555555;
          phase <= 1'b1;
        end else begin
          fail_valid_o <= 1'b1;
          fail_o <= vec & 32'haaaaaaaa;
          done_o <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verification/test_power_on_self_test_reporter.sv]
// Purpose: Self-checking bench of the self-test reporter over its register bus.
// Assumes: Beep tick shortened to 4 cycles.
// Notes: Each fatal pattern needs a fresh reset, since a fatal failure locks the block.
`default_nettype none
module test_power_on_self_test_reporter;
  timeunit 1ns;
  timeprecision 1ns;
  import pst_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, disp_code_o, test_fail_i;
  logic wb_ack_o, irq_o, test_start_o, plugin_inhibit_o, preserve_state_o;
  logic test_fail_valid_i, test_done_i, disp_all_seg_o, annunciator_o;
  logic ready_o, locked_o, beeper_o, remote_valid_o;
  logic [7:0] disp_err_num_o, remote_code_o;
  logic [3:0] disp_digits_o;
  pst_kind_t test_kind_o;
  pst_msg_t disp_msg_o;
  logic [31:0] fvec = 32'h0;
  logic [31:0] nvec = 32'hffffff;
  logic [31:0] dvec = 32'h0;
  logic [7:0] dly = 8'h3;
  int fails = 0;
  int samples_checked = 0;
  logic [15:0] pats [7] = '{16'h0001, 16'h0040, 16'h0200, 16'h0800, 16'h1000, 16'h2000,
                            16'hffff};

  always #25 clk_i = ~clk_i;

  pst_reporter #(.TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .test_start_o(test_start_o), .test_kind_o(test_kind_o),
    .plugin_inhibit_o(plugin_inhibit_o), .preserve_state_o(preserve_state_o),
    .test_fail_valid_i(test_fail_valid_i), .test_fail_i(test_fail_i),
    .test_done_i(test_done_i), .disp_err_num_o(disp_err_num_o), .disp_code_o(disp_code_o),
    .disp_digits_o(disp_digits_o), .disp_msg_o(disp_msg_o), .disp_all_seg_o(disp_all_seg_o),
    .annunciator_o(annunciator_o), .ready_o(ready_o), .locked_o(locked_o),
    .beeper_o(beeper_o), .remote_code_o(remote_code_o), .remote_valid_o(remote_valid_o));

  pst_engine_model eng (.clk_i(clk_i), .rst_i(rst_i), .start_i(test_start_o),
    .kind_i(test_kind_o), .fatal_vec_i(fvec), .nonfatal_vec_i(nvec), .demand_vec_i(dvec),
    .delay_i(dly), .fail_valid_o(test_fail_valid_i), .fail_o(test_fail_i),
    .done_o(test_done_i));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycle; waits for ack without assuming its latency
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      end_sim();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, adr, d, x);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, adr, 32'h0, x);
    chk(x, exp);
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: sig = locked_o;
      1: sig = ready_o;
      2: sig = beeper_o;
      default: sig = disp_all_seg_o;
    endcase
  endfunction

  task automatic wait_for(input int w, input logic lvl);
    int n;
    n = 0;
    while (sig(w) !== lvl && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    if (sig(w) !== lvl) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [7:0] reduced(input logic [15:0] f);
    reduced = {2'b00, f[13], f[12], 1'b0, |f[11:10], |{f[15:14], f[9:6]}, |f[5:0]};
  endfunction

  initial begin
    #(50 * 100000);
    fails++;
    end_sim();
  end

  initial begin
    do_reset();
    // Outputs launched at the first edge after release are seen one edge later
    @(posedge clk_i);
    chk(32'(test_start_o), 32'h1);
    chk(32'(test_kind_o), 32'(KIND_FATAL));
    chk(32'(plugin_inhibit_o), 32'h1);
    wr(OFF_IRQ_MASK, 32'h1f);
    wait_for(1, 1'b1);
    chk(32'(disp_err_num_o), 32'h26);
    chk(32'(annunciator_o), 32'h1);
    chk(32'(locked_o), 32'h0);
    chk(disp_code_o, 32'h007fffff);
    chk(32'(disp_digits_o), 32'h6);
    chk(32'(remote_code_o), 32'h0);
    chk(32'(remote_valid_o), 32'h1);
    chk(32'(disp_msg_o), 32'(MSG_POWER_ON_FAILED));
    rdchk(OFF_ERROR_STRING_QUERY, 32'h267fffff);
    rdchk(OFF_NONFATAL, 32'h007fffff);
    chk(32'(irq_o), 32'h1);
    rdchk(OFF_IRQ_STATUS, 32'h6);
    wr(OFF_IRQ_MASK, 32'h0);
    chk(32'(irq_o), 32'h0);
    wr(OFF_IRQ_MASK, 32'h1f);
    wr(OFF_IRQ_STATUS, 32'h6);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    rdchk(8'h40, 32'h0);
    dvec <= 32'hffffffff;
    dly <= 8'd20;
    wr(OFF_CTRL, 32'h1);
    wait_for(3, 1'b1);
    chk(32'(preserve_state_o), 32'h1);
    chk(32'(plugin_inhibit_o), 32'h1);
    chk(32'(test_kind_o), 32'(KIND_DEMAND));
    repeat (2) @(posedge clk_i);
    chk(32'(beeper_o), 32'h1);
    wait_for(3, 1'b0);
    chk(32'(disp_msg_o), 32'(MSG_SELF_TEST_FAILED));
    chk(32'(disp_err_num_o), 32'h27);
    chk(32'(disp_digits_o), 32'h8);
    chk(disp_code_o, 32'h01fffbff);
    chk(32'(preserve_state_o), 32'h0);
    chk(32'(annunciator_o), 32'h1);
    wait_for(2, 1'b1);
    rdchk(OFF_DEMAND, 32'h01fffbff);
    dvec <= 32'h0;
    dly <= 8'd6;
    wr(OFF_CTRL, 32'h1);
    wait_for(3, 1'b1);
    wait_for(3, 1'b0);
    chk(32'(disp_msg_o), 32'(MSG_SELF_TEST_OK));
    chk(32'(disp_err_num_o), 32'h0);
    chk(disp_code_o, 32'h0);
    rdchk(OFF_DEMAND, 32'h0);
    rdchk(OFF_IRQ_STATUS, 32'h18);
    dly <= 8'h0;
    foreach (pats[i]) begin
      fvec <= {16'h0, pats[i]};
      do_reset();
      wait_for(0, 1'b1);
      chk(32'(disp_err_num_o), 32'h80);
      chk(32'(disp_digits_o), 32'h4);
      chk(disp_code_o, {16'h0, pats[i]});
      chk(32'(remote_code_o & 8'h77), 32'(reduced(pats[i])));
      chk(32'(ready_o), 32'h0);
    end
    wait_for(2, 1'b1);
    rdchk(OFF_FATAL, 32'h0000ffff);
    wr(OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk_i);
    chk(32'(disp_all_seg_o), 32'h0);
    chk(32'(locked_o), 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
